/* File: hw/fault_logger_pkg.sv */
// Overview of operation
// - A message switches the display to the message fault indication.
// - The active message code blinks until the fault is reset.
// - Configuration selects inhibit on a message and restart on reset.
// - Messages fill an eight-entry history, newest shown first.
// - Switching mains power on clears the whole message history.
// - A warning switches the display to the warning fault indication, unless a message arrives in the same cycle.
// - The active warning code blinks until the fault is reset.
// - Warnings fill a second eight-entry history, newest shown first.
// - Mains power-on leaves the warning history untouched.
// - Six supply, trip and following message codes plus a none code.
// - Warning codes cover drive, supply, feedback and link faults.
// - Master current below 2 mA with input mode 1 raises a warning.
package fault_logger_pkg;

  // ---------------------------------------------------------------------
  // History geometry
  // ---------------------------------------------------------------------
  localparam int HIST_DEPTH = 8;
  localparam int MSG_CODE_W = 3;
  localparam int WARN_CODE_W = 5;

  // ---------------------------------------------------------------------
  // Message class codes
  // ---------------------------------------------------------------------
  localparam logic [2:0] MSG_NONE = 3'h0;
  localparam logic [2:0] MSG_EXTERNAL_TRIP_FAULT = 3'h1;
  localparam logic [2:0] MSG_LOW_MAINS_FREQUENCY_FAULT = 3'h2;
  localparam logic [2:0] MSG_MAINS_UNDERVOLTAGE_FAULT = 3'h3;
  localparam logic [2:0] MSG_PHASE_LOSS_FAULT = 3'h4;
  localparam logic [2:0] MSG_HIGH_MAINS_FREQUENCY_FAULT = 3'h5;
  localparam logic [2:0] MSG_FOLLOWING_ERROR_FAULT = 3'h6;

  // ---------------------------------------------------------------------
  // Warning class codes
  // ---------------------------------------------------------------------
  localparam logic [4:0] WARN_NONE = 5'h00;
  localparam logic [4:0] WARN_ARMATURE_BREAK_FAULT = 5'h01;
  localparam logic [4:0] WARN_COMM_AUTOMATION_FAULT = 5'h02;
  localparam logic [4:0] WARN_COMM_SERIAL_FAULT = 5'h03;
  localparam logic [4:0] WARN_BLOCKED_MOTOR_FAULT = 5'h04;
  localparam logic [4:0] WARN_EXTERNAL_TRIP_FAULT = 5'h05;
  localparam logic [4:0] WARN_EXCITATION_BREAK_FAULT = 5'h06;
  localparam logic [4:0] WARN_CONTROLLER_OVERLOAD_FAULT = 5'h07;
  localparam logic [4:0] WARN_MOTOR_OVERLOAD_FAULT = 5'h08;
  localparam logic [4:0] WARN_HEATSINK_OVERTEMP_FAULT = 5'h09;
  localparam logic [4:0] WARN_MAINS_OVERVOLTAGE_FAULT = 5'h0a;
  localparam logic [4:0] WARN_FOLLOWING_ERROR_FAULT = 5'h0b;
  localparam logic [4:0] WARN_TACHO_FAULT = 5'h0c;
  localparam logic [4:0] WARN_RESOLVER_OPEN_FAULT = 5'h0d;
  localparam logic [4:0] WARN_ENCODER_A_FAULT = 5'h0e;
  localparam logic [4:0] WARN_ENCODER_B_FAULT = 5'h0f;
  localparam logic [4:0] WARN_MASTER_CURRENT_LOSS_FAULT = 5'h10;
  localparam logic [4:0] WARN_SOURCE_POLARITY_FAULT = 5'h11;
  localparam logic [4:0] WARN_AUX_SUPPLY_MISSING_FAULT = 5'h12;

  // ---------------------------------------------------------------------
  // Master current supervision
  // ---------------------------------------------------------------------
  localparam logic [15:0] MASTER_CURRENT_MIN_UA = 16'h07d0;
  localparam logic [1:0] MASTER_MODE_CURRENT = 2'h1;

  // ---------------------------------------------------------------------
  // Blink timing
  // ---------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int BLINK_HALF_PERIOD_MS = 500;
  localparam int BLINK_HALF_CYCLES = BLINK_HALF_PERIOD_MS * 1000000
                                     / CLK_PERIOD_NS;

  // ---------------------------------------------------------------------
  // Display selection states
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    DISP_IDLE = 3'b001,
    DISP_MESSAGE = 3'b010,
    DISP_WARNING = 3'b100
  } display_state_e;

endpackage : fault_logger_pkg

/* File: hw/fault_history.sv */
`timescale 1ns/1ps
`default_nettype none

module fault_history
  #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 8
  )
  (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic clear_in,
    input wire logic push_in,
    input wire logic [WIDTH-1:0] code_in,
    input wire logic [$clog2(DEPTH)-1:0] index_in,
    output logic [WIDTH-1:0] entry_out
  );

  // ---------------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------------
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
  begin : g_bad_param
    $error("fault_history needs a power-of-two depth of two or more.");
  end

  logic [WIDTH-1:0] entry_ff [DEPTH];
  logic [WIDTH-1:0] nxt_entry [DEPTH];

  // ---------------------------------------------------------------------
  // Shift store
  // ---------------------------------------------------------------------
  // Slot 0 is the newest entry; a push moves every entry one slot older
  // and the oldest falls off the end. A push in the same cycle as a
  // clear survives the clear.
  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      nxt_entry[i] = clear_in ? '0 : entry_ff[i];
    end
    if (push_in)
    begin
      for (int i = DEPTH - 1; i > 0; i--)
      begin
        nxt_entry[i] = clear_in ? '0 : entry_ff[i-1];
      end
      nxt_entry[0] = code_in;
    end
  end

  // Registers the store.
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        entry_ff[i] <= '0;
      end
    end
    else
    begin
      entry_ff <= nxt_entry;
    end
  end

  // Selects the entry that the viewer asks for.
  assign entry_out = entry_ff[index_in];

endmodule : fault_history

`default_nettype wire

/* File: hw/fault_event_history_logger.sv */
`timescale 1ns/1ps
`default_nettype none

module fault_event_history_logger
  import fault_logger_pkg::*;
  #(
    parameter int BLINK_CYCLES = BLINK_HALF_CYCLES
  )
  (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic mains_power_on_in,
    input wire logic message_event_in,
    input wire logic [MSG_CODE_W-1:0] message_code_in,
    input wire logic warning_event_in,
    input wire logic [WARN_CODE_W-1:0] warning_code_in,
    input wire logic [15:0] master_current_ua_in,
    input wire logic [1:0] master_current_input_mode_in,
    input wire logic fault_reset_in,
    input wire logic fault_reaction_config_a_in,
    input wire logic fault_reaction_config_b_in,
    input wire logic drive_restart_in,
    input wire logic key_down_in,
    input wire logic key_up_in,
    output logic show_message_fault_indication_out,
    output logic show_warning_fault_indication_out,
    output logic [WARN_CODE_W-1:0] display_code_out,
    output logic display_lit_out,
    output logic [2:0] history_index_out,
    output logic message_active_out,
    output logic warning_active_out,
    output logic drive_inhibit_out
  );

  localparam int CNT_W = $clog2(BLINK_CYCLES + 1);
  localparam logic [2:0] VIEW_LAST = 3'(HIST_DEPTH - 1);

  // ---------------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------------
  if (BLINK_CYCLES < 1 || HIST_DEPTH != 8)
  begin : g_bad_param
    $error("Blink count must be positive and history depth must be 8.");
  end

  // ---------------------------------------------------------------------
  // Event qualification
  // ---------------------------------------------------------------------
  logic msg_take;
  logic warn_ext_take;
  logic loss_cond;
  logic loss_take;
  logic warn_take;
  logic [WARN_CODE_W-1:0] warn_code;
  logic loss_seen_ff;
  logic nxt_loss_seen;

  // Only codes inside each class count; the no-fault code is dropped.
  assign msg_take = message_event_in &&
                    message_code_in != MSG_NONE &&
                    message_code_in <= MSG_FOLLOWING_ERROR_FAULT;
  assign warn_ext_take = warning_event_in &&
                         warning_code_in != WARN_NONE &&
                         warning_code_in <=
                         WARN_AUX_SUPPLY_MISSING_FAULT;

  // A falling master current is a warning in current-input mode only.
  assign loss_cond = master_current_input_mode_in == MASTER_MODE_CURRENT &&
                     master_current_ua_in < MASTER_CURRENT_MIN_UA;
  // An outside warning in the same cycle goes first; the loss retries.
  assign loss_take = loss_cond && !loss_seen_ff && !warn_ext_take;
  assign warn_take = warn_ext_take || loss_take;
  assign warn_code = warn_ext_take ? warning_code_in
                                   : WARN_MASTER_CURRENT_LOSS_FAULT;

  // ---------------------------------------------------------------------
  // Active fault flags and drive inhibit
  // ---------------------------------------------------------------------
  logic msg_active_ff;
  logic warn_active_ff;
  logic inhibit_ff;
  logic nxt_msg_active;
  logic nxt_warn_active;
  logic nxt_inhibit;

  // A new fault wins over a reset arriving in the same cycle. The loss
  // flag remembers that the present loss episode has been recorded.
  always_comb
  begin
    nxt_loss_seen = loss_cond && (loss_seen_ff || loss_take);
    nxt_msg_active = msg_take || (msg_active_ff && !fault_reset_in);
    nxt_warn_active = warn_take || (warn_active_ff && !fault_reset_in);
    nxt_inhibit = inhibit_ff;
    if (fault_reset_in && fault_reaction_config_b_in)
    begin
      nxt_inhibit = 1'b0;
    end
    if (drive_restart_in && !msg_active_ff)
    begin
      nxt_inhibit = 1'b0;
    end
    if (msg_take && fault_reaction_config_a_in)
    begin
      nxt_inhibit = 1'b1;
    end
  end

  // Registers the fault flags.
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      msg_active_ff <= 1'b0;
      loss_seen_ff <= 1'b0;
      warn_active_ff <= 1'b0;
      inhibit_ff <= 1'b0;
    end
    else
    begin
      msg_active_ff <= nxt_msg_active;
      loss_seen_ff <= nxt_loss_seen;
      warn_active_ff <= nxt_warn_active;
      inhibit_ff <= nxt_inhibit;
    end
  end

  // ---------------------------------------------------------------------
  // Fault histories
  // ---------------------------------------------------------------------
  logic [2:0] view_ff;
  logic [MSG_CODE_W-1:0] msg_entry;
  logic [WARN_CODE_W-1:0] warn_entry;

  // Message history, wiped whenever the mains come up.
  fault_history #(
    .WIDTH(MSG_CODE_W),
    .DEPTH(HIST_DEPTH)
  ) u_message_history (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .clear_in(mains_power_on_in),
    .push_in(msg_take),
    .code_in(message_code_in),
    .index_in(view_ff),
    .entry_out(msg_entry)
  );

  // Warning history, which mains power-on leaves untouched.
  fault_history #(
    .WIDTH(WARN_CODE_W),
    .DEPTH(HIST_DEPTH)
  ) u_warning_history (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .clear_in(1'b0),
    .push_in(warn_take),
    .code_in(warn_code),
    .index_in(view_ff),
    .entry_out(warn_entry)
  );

  // ---------------------------------------------------------------------
  // Display selection and scrolling
  // ---------------------------------------------------------------------
  display_state_e disp_ff;
  display_state_e nxt_disp;
  logic [2:0] nxt_view;

  // A new fault switches the display to its class and jumps to the
  // newest entry; a message outranks a warning in the same cycle. Down
  // steps to older entries and up back to newer ones.
  always_comb
  begin
    nxt_disp = disp_ff;
    nxt_view = view_ff;
    if (disp_ff != DISP_IDLE && key_down_in && !key_up_in &&
        view_ff != VIEW_LAST)
    begin
      nxt_view = view_ff + 3'h1;
    end
    if (disp_ff != DISP_IDLE && key_up_in && !key_down_in &&
        view_ff != 3'h0)
    begin
      nxt_view = view_ff - 3'h1;
    end
    if (msg_take)
    begin
      nxt_disp = DISP_MESSAGE;
      nxt_view = 3'h0;
    end
    else if (warn_take)
    begin
      nxt_disp = DISP_WARNING;
      nxt_view = 3'h0;
    end
  end

  // Registers the display selection.
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      disp_ff <= DISP_IDLE;
      view_ff <= 3'h0;
    end
    else
    begin
      disp_ff <= nxt_disp;
      view_ff <= nxt_view;
    end
  end

  // ---------------------------------------------------------------------
  // Blink timer and display output
  // ---------------------------------------------------------------------
  logic [CNT_W-1:0] blink_cnt_ff;
  logic [CNT_W-1:0] nxt_blink_cnt;
  logic blink_phase_ff;
  logic nxt_blink_phase;
  logic [WARN_CODE_W-1:0] code_ff;
  logic [WARN_CODE_W-1:0] nxt_code;
  logic lit_ff;
  logic nxt_lit;
  logic shown_active;

  // The blink phase toggles every half period, and the newest entry of
  // a class with a fault still pending blinks with it.
  always_comb
  begin
    nxt_blink_cnt = blink_cnt_ff + 1'b1;
    nxt_blink_phase = blink_phase_ff;
    if (blink_cnt_ff == CNT_W'(BLINK_CYCLES - 1))
    begin
      nxt_blink_cnt = '0;
      nxt_blink_phase = !blink_phase_ff;
    end
    nxt_code = WARN_NONE;
    shown_active = 1'b0;
    unique case (disp_ff)
      DISP_IDLE:
      begin
        nxt_code = WARN_NONE;
      end
      DISP_MESSAGE:
      begin
        nxt_code = {{(WARN_CODE_W - MSG_CODE_W){1'b0}}, msg_entry};
        shown_active = msg_active_ff && view_ff == 3'h0;
      end
      DISP_WARNING:
      begin
        nxt_code = warn_entry;
        shown_active = warn_active_ff && view_ff == 3'h0;
      end
      default:
      begin
        nxt_code = WARN_NONE;
      end
    endcase
    nxt_lit = !(shown_active && blink_phase_ff);
  end

  // Registers the blink timer and the display drive.
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      blink_cnt_ff <= '0;
      blink_phase_ff <= 1'b0;
      code_ff <= WARN_NONE;
      lit_ff <= 1'b1;
    end
    else
    begin
      blink_cnt_ff <= nxt_blink_cnt;
      blink_phase_ff <= nxt_blink_phase;
      code_ff <= nxt_code;
      lit_ff <= nxt_lit;
    end
  end

  // Drives the ports from registers.
  assign show_message_fault_indication_out = disp_ff == DISP_MESSAGE;
  assign show_warning_fault_indication_out = disp_ff == DISP_WARNING;
  assign display_code_out = code_ff;
  assign display_lit_out = lit_ff;
  assign history_index_out = view_ff;
  assign message_active_out = msg_active_ff;
  assign warning_active_out = warn_active_ff;
  assign drive_inhibit_out = inhibit_ff;

endmodule : fault_event_history_logger

`default_nettype wire

/* File: test/fault_logger_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

module fault_logger_asserts
  import fault_logger_pkg::*;
  #(
    parameter int BLINK_CYCLES = 4
  )
  (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic mains_power_on_in,
    input wire logic message_event_in,
    input wire logic [MSG_CODE_W-1:0] message_code_in,
    input wire logic warning_event_in,
    input wire logic [WARN_CODE_W-1:0] warning_code_in,
    input wire logic [15:0] master_current_ua_in,
    input wire logic [1:0] master_current_input_mode_in,
    input wire logic fault_reset_in,
    input wire logic fault_reaction_config_a_in,
    input wire logic drive_restart_in,
    input wire logic key_down_in,
    input wire logic key_up_in,
    input wire logic show_message_fault_indication_out,
    input wire logic show_warning_fault_indication_out,
    input wire logic [WARN_CODE_W-1:0] display_code_out,
    input wire logic display_lit_out,
    input wire logic [2:0] history_index_out,
    input wire logic message_active_out,
    input wire logic warning_active_out,
    input wire logic drive_inhibit_out
  );

  // ---------------------------------------------------------------
  // Decoded request conditions
  // ---------------------------------------------------------------
  // Accepted events, the current loss condition and a quiet cycle.
  wire logic msg_ok = message_event_in &&
                      (message_code_in inside {[3'h1:3'h6]});
  wire logic warn_ok = warning_event_in &&
                       (warning_code_in inside {[5'h01:5'h12]});
  wire logic loss = (master_current_input_mode_in == MASTER_MODE_CURRENT)
                    && (master_current_ua_in < MASTER_CURRENT_MIN_UA);
  wire logic quiet = !message_event_in && !warning_event_in && !key_down_in
                     && !key_up_in && !mains_power_on_in && !loss;

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!reset_n_in);

  a_msg_show: assert property (msg_ok |=>
    show_message_fault_indication_out && message_active_out)
    else $error("message not shown");
  a_warn_show: assert property (warn_ok && !msg_ok |=>
    show_warning_fault_indication_out && warning_active_out)
    else $error("warning not shown");
  a_event_index: assert property (msg_ok |=>
    history_index_out == 3'h0) else $error("view not reset to newest");
  a_msg_code: assert property (msg_ok && !warning_event_in
    ##1 quiet |=> display_code_out == {2'h0, $past(message_code_in, 2)})
    else $error("wrong message code shown");
  a_inhibit_set: assert property (msg_ok &&
    fault_reaction_config_a_in |=> drive_inhibit_out)
    else $error("drive not inhibited");
  a_inhibit_hold: assert property (drive_inhibit_out &&
    !fault_reset_in && !drive_restart_in |=> drive_inhibit_out)
    else $error("inhibit lost");
  a_reset_clears: assert property (fault_reset_in &&
    !message_event_in && !warning_event_in && !loss |=>
    !message_active_out) else $error("message stays active");
  a_lit_idle: assert property (
    (!message_active_out && !warning_active_out)[*3] |-> display_lit_out)
    else $error("blanked with no fault");
  a_index_sat: assert property (history_index_out == 3'h7 &&
    key_down_in && !key_up_in && !message_event_in && !warning_event_in
    && !loss |=> history_index_out == 3'h7)
    else $error("index passed oldest");
  a_loss_warn: assert property ($rose(loss) && !fault_reset_in |=>
    warning_active_out) else $error("current loss missed");

  // Main scenarios reached.
  cover property (msg_ok && fault_reaction_config_a_in);
  cover property (history_index_out == 3'h7 && key_down_in);
  cover property (loss && warning_active_out);

endmodule : fault_logger_asserts

bind fault_event_history_logger fault_logger_asserts
  #(.BLINK_CYCLES(BLINK_CYCLES)) chk_u (
  .mclk_in(mclk_in), .reset_n_in(reset_n_in),
  .mains_power_on_in(mains_power_on_in),
  .message_event_in(message_event_in), .message_code_in(message_code_in),
  .warning_event_in(warning_event_in), .warning_code_in(warning_code_in),
  .master_current_ua_in(master_current_ua_in),
  .master_current_input_mode_in(master_current_input_mode_in),
  .fault_reset_in(fault_reset_in),
  .fault_reaction_config_a_in(fault_reaction_config_a_in),
  .drive_restart_in(drive_restart_in),
  .key_down_in(key_down_in), .key_up_in(key_up_in),
  .show_message_fault_indication_out(show_message_fault_indication_out),
  .show_warning_fault_indication_out(show_warning_fault_indication_out),
  .display_code_out(display_code_out), .display_lit_out(display_lit_out),
  .history_index_out(history_index_out),
  .message_active_out(message_active_out),
  .warning_active_out(warning_active_out),
  .drive_inhibit_out(drive_inhibit_out));

`default_nettype wire

/* File: test/keypad_model.sv */
`timescale 1ns/1ps
`default_nettype none

module keypad_model
  (
    input wire logic mclk_in,
    output logic key_down_out,
    output logic key_up_out
  );

  // Keys rest released.
  initial
  begin
    key_down_out = 1'b0;
    key_up_out = 1'b0;
  end

  // One key held for exactly one clock edge, called just after an edge.
  task automatic press(input logic down);
    key_down_out = down;
    key_up_out = !down;
    @(posedge mclk_in);
    #1;
    key_down_out = 1'b0;
    key_up_out = 1'b0;
  endtask : press

endmodule : keypad_model

`default_nettype wire

/* File: test/fault_event_history_logger_test.sv */
`timescale 1ns/1ps
`default_nettype none

module fault_event_history_logger_test
  import fault_logger_pkg::*;
  ;

  logic mclk_in;
  logic reset_n_in;
  logic mains_power_on_in;
  logic message_event_in;
  logic [2:0] message_code_in;
  logic warning_event_in;
  logic [4:0] warning_code_in;
  logic [15:0] master_current_ua_in;
  logic [1:0] master_current_input_mode_in;
  logic fault_reset_in;
  logic fault_reaction_config_a_in;
  logic fault_reaction_config_b_in;
  logic drive_restart_in;
  logic key_down_in;
  logic key_up_in;
  logic show_msg;
  logic show_warn;
  logic [4:0] display_code;
  logic display_lit;
  logic [2:0] index;
  logic msg_active;
  logic warn_active;
  logic inhibit;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;

  fault_event_history_logger #(.BLINK_CYCLES(4)) dut_u (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .mains_power_on_in(mains_power_on_in),
    .message_event_in(message_event_in), .message_code_in(message_code_in),
    .warning_event_in(warning_event_in), .warning_code_in(warning_code_in),
    .master_current_ua_in(master_current_ua_in),
    .master_current_input_mode_in(master_current_input_mode_in),
    .fault_reset_in(fault_reset_in),
    .fault_reaction_config_a_in(fault_reaction_config_a_in),
    .fault_reaction_config_b_in(fault_reaction_config_b_in),
    .drive_restart_in(drive_restart_in),
    .key_down_in(key_down_in), .key_up_in(key_up_in),
    .show_message_fault_indication_out(show_msg),
    .show_warning_fault_indication_out(show_warn),
    .display_code_out(display_code), .display_lit_out(display_lit),
    .history_index_out(index), .message_active_out(msg_active),
    .warning_active_out(warn_active), .drive_inhibit_out(inhibit));

  keypad_model kp_u (.mclk_in(mclk_in), .key_down_out(key_down_in),
    .key_up_out(key_up_in));

  // ---------------------------------------------------------------
  // Clock and hang guard
  // ---------------------------------------------------------------
  // Free running 100 MHz clock.
  initial
  begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  // A stuck run is cut off well beyond the expected length.
  always @(posedge mclk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      complete_run();
    end
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  // Inputs always change one nanosecond after a rising edge.
  task automatic step;
    @(posedge mclk_in);
    #1;
  endtask : step

  // Compares one result and reports at once on a difference.
  task automatic check(input logic [4:0] got, input logic [4:0] exp,
                       input string what);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : check

  // Compares one flag, extended to the width of the result check.
  task automatic check_flag(input logic got, input logic exp,
                            input string what);
    check({4'h0, got}, {4'h0, exp}, what);
  endtask : check_flag

  // One-edge pulses for events and the fault reset.
  task automatic post_msg(input logic [2:0] code);
    message_code_in = code;
    message_event_in = 1'b1;
    step();
    message_event_in = 1'b0;
  endtask : post_msg

  task automatic post_warn(input logic [4:0] code);
    warning_code_in = code;
    warning_event_in = 1'b1;
    step();
    warning_event_in = 1'b0;
  endtask : post_warn

  task automatic pulse_reset;
    fault_reset_in = 1'b1;
    step();
    fault_reset_in = 1'b0;
  endtask : pulse_reset

  // Prints the counts and the verdict, then stops.
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Display switch, blinking, inhibit and both ways of restarting.
  task automatic test_message;
    int low;
    fault_reaction_config_a_in = 1'b1;
    post_msg(3'h3);
    check_flag(show_msg, 1'b1, "message shown");
    check_flag(inhibit, 1'b1, "inhibit set");
    step();
    check(display_code, 5'h03, "message code");
    low = 0;
    repeat (12)
    begin
      step();
      if (display_lit === 1'b0)
        low++;
    end
    check(5'(low > 0), 5'h01, "blinking");
    pulse_reset();
    check_flag(msg_active, 1'b0, "active cleared");
    check_flag(inhibit, 1'b1, "inhibit kept");
    repeat (3)
      step();
    check_flag(display_lit, 1'b1, "steady after reset");
    drive_restart_in = 1'b1;
    step();
    drive_restart_in = 1'b0;
    check_flag(inhibit, 1'b0, "restarted");
    fault_reaction_config_b_in = 1'b1;
    post_msg(3'h1);
    pulse_reset();
    check_flag(inhibit, 1'b0, "released by reset");
    fault_reaction_config_a_in = 1'b0;
    post_msg(3'h2);
    check_flag(inhibit, 1'b0, "keeps running");
    $display("test message done");
  endtask : test_message

  // Nine back-to-back messages, full scroll with saturation, bad code.
  task automatic test_history;
    int i;
    int j;
    for (i = 0; i < 9; i++)
    begin
      message_code_in = 3'(i % 6 + 1);
      message_event_in = 1'b1;
      step();
    end
    message_event_in = 1'b0;
    step();
    check(display_code, 5'h03, "newest first");
    for (i = 1; i < 9; i++)
    begin
      j = (i > 7) ? 7 : i;
      kp_u.press(1'b1);
      check(5'(index), 5'(j), "scroll index");
      step();
      check(display_code, 5'((8 - j) % 6 + 1), "scroll entry");
    end
    kp_u.press(1'b0);
    step();
    check(display_code, 5'h03, "scroll up");
    post_msg(3'h7);
    check(5'(index), 5'h06, "bad code ignored");
    $display("test history done");
  endtask : test_history

  // Every warning code, then mains power-on clears only messages.
  task automatic test_warning;
    int i;
    for (i = 1; i <= 18; i++)
    begin
      post_warn(5'(i));
      check_flag(show_warn, 1'b1, "warning shown");
      step();
      check(display_code, 5'(i), "warning code");
    end
    mains_power_on_in = 1'b1;
    step();
    mains_power_on_in = 1'b0;
    post_warn(5'h04);
    step();
    check(display_code, 5'h04, "warning newest");
    kp_u.press(1'b1);
    step();
    check(display_code, 5'h12, "warning kept");
    post_msg(3'h5);
    kp_u.press(1'b1);
    step();
    check(display_code, 5'h00, "messages cleared");
    $display("test warning done");
  endtask : test_warning

  // Current loss only below the threshold and only in current mode.
  task automatic test_loss;
    pulse_reset();
    master_current_input_mode_in = 2'h2;
    master_current_ua_in = 16'h07cf;
    repeat (3)
      step();
    check_flag(warn_active, 1'b0, "wrong mode");
    master_current_input_mode_in = 2'h1;
    master_current_ua_in = 16'h07d0;
    repeat (3)
      step();
    check_flag(warn_active, 1'b0, "at threshold");
    master_current_ua_in = 16'h07cf;
    step();
    step();
    check_flag(warn_active, 1'b1, "loss raised");
    check(display_code, 5'h10, "loss code");
    master_current_ua_in = 16'hffff;
    $display("test loss done");
  endtask : test_loss

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  // Quiet inputs, two cycles of reset, then the scenarios in turn.
  initial
  begin
    reset_n_in = 1'b0;
    mains_power_on_in = 1'b0;
    message_event_in = 1'b0;
    message_code_in = 3'h0;
    warning_event_in = 1'b0;
    warning_code_in = 5'h00;
    master_current_ua_in = 16'hffff;
    master_current_input_mode_in = 2'h0;
    fault_reset_in = 1'b0;
    fault_reaction_config_a_in = 1'b0;
    fault_reaction_config_b_in = 1'b0;
    drive_restart_in = 1'b0;
    repeat (2)
      @(posedge mclk_in);
    #1;
    reset_n_in = 1'b1;
    test_message();
    test_history();
    test_warning();
    test_loss();
    complete_run();
  end

endmodule : fault_event_history_logger_test

`default_nettype wire
